// *** rtl/core_pm_cfg.svh ***
// Constants of the core power-mode controller: register offsets, fields, resets, timing.
`ifndef CORE_PM_CFG_SVH
`define CORE_PM_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PM_OFS_HW_CONFIG   12'h000
`define PM_OFS_STATUS      12'h004
`define PM_OFS_WAKE_CAUSE  12'h008

// ----------------------------------------------------------------------------
// Fields of core_hw_config_reg
// ----------------------------------------------------------------------------
`define PM_BIT_DOZE        0
`define PM_BIT_NAP         1
`define PM_BIT_SLEEP       2
`define PM_BIT_DYN_PM      3
`define PM_CFG_WIDTH       4
`define PM_CFG_RESET       4'h0

// ----------------------------------------------------------------------------
// Status and wake-cause layout
// ----------------------------------------------------------------------------
`define PM_STATE_WIDTH     3
`define PM_BIT_REQ_FLAG    4
`define PM_BIT_ACK_FLAG    5
`define PM_WAKE_WIDTH      6
`define PM_WAKE_RESET      6'h00

// ----------------------------------------------------------------------------
// Timing: dispatch demand keeps a unit powered this many cycles after use
// ----------------------------------------------------------------------------
`define PM_UNIT_HOLD_NS    30
`define PM_CLK_NS          10
`define PM_UNIT_HOLD_CYC   ((`PM_UNIT_HOLD_NS + `PM_CLK_NS - 1) / `PM_CLK_NS)

`endif

// *** rtl/core_pm_pkg.sv ***
// Types of the core power-mode controller.
package core_pm_pkg;

    // ------------------------------------------------------------------------
    // Power states, Gray coded in the order listed
    // ------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        PM_FULL      = 3'h0,
        PM_DOZE      = 3'h1,
        PM_NAP_WAIT  = 3'h3,
        PM_NAP       = 3'h2,
        PM_SLEEP     = 3'h6,
        PM_SLEEP_WAIT = 3'h7,
        PM_WAKE      = 3'h5
    } pm_state_t;

endpackage

// *** rtl/unit_demand_gate.sv ***
// Per-unit power enable driven by instruction dispatch demand.
`include "core_pm_cfg.svh"

module unit_demand_gate #(
    parameter int UNITS = 4,
    parameter int HOLD  = `PM_UNIT_HOLD_CYC
)
(
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    // Control.
    input  wire logic             dyn_pm_en_i,
    input  wire logic             run_i,
    input  wire logic [UNITS-1:0] demand_i,
    // Unit power enables.
    output logic      [UNITS-1:0] unit_on_o
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    if (UNITS < 1 || HOLD < 1 || HOLD > 255)
    begin : g_bad
        $error("unit_demand_gate: bad parameters");
    end

    // ------------------------------------------------------------------------
    // One hold counter per unit
    // ------------------------------------------------------------------------
    for (genvar u = 0; u < UNITS; u++)
    begin : g_unit
        logic [7:0] hold_reg;   // Cycles of power left for this unit.
        logic [7:0] hold_next;  // Next value of the hold counter.
        logic       on_next;    // Next value of the enable.

        // A demand reloads the hold; otherwise it drains to zero.
        always_comb
        begin
            hold_next = hold_reg;
            if (demand_i[u])
            begin
                hold_next = 8'(HOLD);
            end
            else if (hold_reg != 8'h00)
            begin
                hold_next = hold_reg - 8'h01;
            end
            // Without dynamic management every unit stays on while running.
            on_next = run_i && (!dyn_pm_en_i || demand_i[u] || hold_next != 8'h00); // R4
        end

        // Registers only.
        always_ff @(posedge clk_i or posedge reset_i)
        begin
            if (reset_i)
            begin
                hold_reg     <= 8'h00;
                unit_on_o[u] <= 1'b0;
            end
            else
            begin
                hold_reg     <= hold_next;
                unit_on_o[u] <= on_next;
            end
        end
    end

endmodule

// *** rtl/core_power_mode_control.sv ***
// Power-mode controller of the processor core with an APB register slave.
//
// Summary of operation
// R1 - Core modes independent of peripheral modes.
// R2 - Low-power modes entered only by register write.
// R3 - Core state kept; clocks gated, never reset.
// R4 - Dynamic management powers units on demand.
// R5 - Doze entered at once, no acknowledge.
// R6 - Doze keeps snoop, decrementer, data cache.
// R7 - Doze wakes on interrupt, decrementer, reset, check.
// R8 - Nap and sleep wait for quiesce acknowledge.
// R9 - Nap: decrementer only; wake includes acknowledge loss.
// R10 - Sleep: nothing runs; decrementer does not wake.
// R11 - Quiesce request asserted in nap and sleep.
// R12 - Peripheral keeps acknowledge during memory access.
// R13 - Wake returns full power, drops request first.
`include "core_pm_cfg.svh"

module core_power_mode_control #(
    parameter int UNITS = 4
)
(
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    // APB slave.
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Wake sources, asynchronous pins.
    input  wire logic             system_mgmt_interrupt_i,
    input  wire logic             ext_int_i,
    input  wire logic             decrementer_exc_i,
    input  wire logic             soft_reset_i,
    input  wire logic             machine_check_i,
    // Quiesce handshake with peripheral logic.
    input  wire logic             quiesce_acknowledge_i,
    output logic                  quiesce_request_o,
    // Dispatch demand and unit enables.
    input  wire logic [UNITS-1:0] dispatch_demand_i,
    output logic      [UNITS-1:0] unit_on_o,
    // Clock gates of the core domains.
    output logic                  core_clk_en_o,
    output logic                  snoop_en_o,
    output logic                  dcache_en_o,
    output logic                  decrementer_en_o
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    if (UNITS < 1 || UNITS > 16)
    begin : g_bad
        $error("core_power_mode_control: UNITS out of range");
    end

    // ------------------------------------------------------------------------
    // Input synchronisers: six asynchronous pins, two stages each
    // ------------------------------------------------------------------------
    logic [5:0] async_in;   // Raw pins.
    logic [5:0] sync1_reg;  // First stage, read only by the second.
    logic [5:0] sync2_reg;  // Second stage, safe for logic.

    assign async_in = {quiesce_acknowledge_i, machine_check_i, soft_reset_i,
                       decrementer_exc_i, ext_int_i, system_mgmt_interrupt_i};

    // Plain two-flop chains; no logic between stages.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end
        else
        begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic mgmt_s, int_s, dec_s, srst_s, mcp_s, ack_s; // Synchronised levels.
    assign {ack_s, mcp_s, srst_s, dec_s, int_s, mgmt_s} = sync2_reg;

    // ------------------------------------------------------------------------
    // Register file and state
    // ------------------------------------------------------------------------
    logic [`PM_CFG_WIDTH-1:0]  cfg_reg, cfg_next;     // Core hardware config.
    logic [`PM_WAKE_WIDTH-1:0] wake_reg, wake_next;   // Sticky wake causes.
    core_pm_pkg::pm_state_t    state_reg, state_next; // Power state.
    logic [31:0]               prdata_next;           // Read mux.
    logic                      pslverr_next;          // Unmapped address.
    logic                      req_next;              // Quiesce request.
    logic                      wr_cfg, wr_wake;       // Write strobes.
    logic [`PM_WAKE_WIDTH-1:0] wake_src;              // Live wake reasons.
    logic                      do_wake;               // Leave the mode.

    wire access = psel && penable;
    assign wr_cfg  = access && pwrite && paddr == `PM_OFS_HW_CONFIG;
    assign wr_wake = access && pwrite && paddr == `PM_OFS_WAKE_CAUSE;

    // Wake sources valid in the present mode.
    always_comb
    begin
        wake_src = {mcp_s, srst_s, !ack_s, dec_s, int_s, mgmt_s};
        case (state_reg)
            core_pm_pkg::PM_DOZE:
            begin
                wake_src[3] = 1'b0; // R7
            end
            core_pm_pkg::PM_NAP:
            begin
                wake_src = wake_src; // R9
            end
            core_pm_pkg::PM_SLEEP:
            begin
                wake_src[2] = 1'b0; // R10
            end
            default:
            begin
                wake_src = '0;
            end
        endcase
        do_wake = |wake_src;
    end

    // Next state, register updates and read data.
    always_comb
    begin
        state_next   = state_reg;
        cfg_next     = cfg_reg;
        wake_next    = wake_reg;
        prdata_next  = 32'h0000_0000;
        pslverr_next = 1'b0;
        // Software clears cause bits by writing ones; a new cause wins.
        if (wr_wake)
        begin
            wake_next = wake_next & ~pwdata[`PM_WAKE_WIDTH-1:0];
        end
        if (wr_cfg)
        begin
            cfg_next = pwdata[`PM_CFG_WIDTH-1:0];
        end
        case (state_reg)
            core_pm_pkg::PM_FULL:
            begin
                // Only a config write moves the core down; sleep beats nap beats doze.
                if (wr_cfg && pwdata[`PM_BIT_SLEEP])           // R2
                begin
                    state_next = core_pm_pkg::PM_SLEEP_WAIT;
                end
                else if (wr_cfg && pwdata[`PM_BIT_NAP])
                begin
                    state_next = core_pm_pkg::PM_NAP_WAIT;
                end
                else if (wr_cfg && pwdata[`PM_BIT_DOZE])
                begin
                    state_next = core_pm_pkg::PM_DOZE;          // R5
                end
            end
            core_pm_pkg::PM_NAP_WAIT:
            begin
                // Request out, waiting for acknowledge.
                if (mcp_s || srst_s || mgmt_s || int_s || dec_s)
                begin
                    state_next = core_pm_pkg::PM_WAKE;
                end
                else if (ack_s)
                begin
                    state_next = core_pm_pkg::PM_NAP;           // R8
                end
            end
            core_pm_pkg::PM_SLEEP_WAIT:
            begin
                if (mcp_s || srst_s || mgmt_s || int_s)
                begin
                    state_next = core_pm_pkg::PM_WAKE;
                end
                else if (ack_s)
                begin
                    state_next = core_pm_pkg::PM_SLEEP;         // R8
                end
            end
            core_pm_pkg::PM_DOZE, core_pm_pkg::PM_NAP, core_pm_pkg::PM_SLEEP:
            begin
                // Acknowledge held through peripheral memory access keeps nap.
                if (do_wake)                                    // R12
                begin
                    state_next = core_pm_pkg::PM_WAKE;
                    wake_next  = wake_next | wake_src;
                end
            end
            core_pm_pkg::PM_WAKE:
            begin
                // Request already dropped here; mode bits cleared on return.
                state_next = core_pm_pkg::PM_FULL;              // R13
                cfg_next   = cfg_reg & `PM_CFG_WIDTH'(1 << `PM_BIT_DYN_PM);
            end
            default:
            begin
                state_next = core_pm_pkg::PM_FULL;
            end
        endcase
        // Read mux.
        if (psel && !pwrite)
        begin
            case (paddr)
                `PM_OFS_HW_CONFIG:
                begin
                    prdata_next = 32'(cfg_reg);
                end
                `PM_OFS_STATUS:
                begin
                    prdata_next = 32'(state_reg);
                    prdata_next[`PM_BIT_REQ_FLAG] = quiesce_request_o;
                    prdata_next[`PM_BIT_ACK_FLAG] = ack_s;
                end
                `PM_OFS_WAKE_CAUSE:
                begin
                    prdata_next = 32'(wake_reg);
                end
                default:
                begin
                    prdata_next = 32'h0000_0000;
                end
            endcase
        end
        if (psel && paddr != `PM_OFS_HW_CONFIG && paddr != `PM_OFS_STATUS
            && paddr != `PM_OFS_WAKE_CAUSE)
        begin
            pslverr_next = 1'b1;
        end
        // Request stands in nap, sleep and their entry waits.
        req_next = state_next == core_pm_pkg::PM_NAP_WAIT
                 || state_next == core_pm_pkg::PM_NAP
                 || state_next == core_pm_pkg::PM_SLEEP_WAIT
                 || state_next == core_pm_pkg::PM_SLEEP;       // R11
    end

    // Registers only. Core state itself is never reset by mode changes.  R3
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg         <= core_pm_pkg::PM_FULL;
            cfg_reg           <= `PM_CFG_RESET;
            wake_reg          <= `PM_WAKE_RESET;
            prdata            <= 32'h0000_0000;
            pready            <= 1'b0;
            pslverr           <= 1'b0;
            quiesce_request_o <= 1'b0;
            core_clk_en_o     <= 1'b1;
            snoop_en_o        <= 1'b1;
            dcache_en_o       <= 1'b1;
            decrementer_en_o  <= 1'b1;
        end
        else
        begin
            state_reg         <= state_next;
            cfg_reg           <= cfg_next;
            wake_reg          <= wake_next;
            prdata            <= prdata_next;
            pready            <= psel && !penable;
            pslverr           <= pslverr_next;
            quiesce_request_o <= req_next;
            // Clock gates follow the target state; this block owns only core domains. R1
            core_clk_en_o     <= state_next == core_pm_pkg::PM_FULL
                              || state_next == core_pm_pkg::PM_WAKE;
            snoop_en_o        <= state_next != core_pm_pkg::PM_NAP
                              && state_next != core_pm_pkg::PM_SLEEP;   // R6
            dcache_en_o       <= state_next != core_pm_pkg::PM_NAP
                              && state_next != core_pm_pkg::PM_SLEEP;   // R6
            decrementer_en_o  <= state_next != core_pm_pkg::PM_SLEEP; // R10
        end
    end

    // ------------------------------------------------------------------------
    // Demand-driven unit power
    // ------------------------------------------------------------------------
    unit_demand_gate #(
        .UNITS (UNITS),
        .HOLD  (`PM_UNIT_HOLD_CYC)
    ) u_gate (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .dyn_pm_en_i (cfg_reg[`PM_BIT_DYN_PM]),
        .run_i     (state_reg == core_pm_pkg::PM_FULL),
        .demand_i  (dispatch_demand_i),
        .unit_on_o (unit_on_o)
    );

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    chk_quiesce_request_in_nap: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == core_pm_pkg::PM_NAP |-> quiesce_request_o)
        else $error("quiesce request low in nap"); // R11
    chk_nap_needs_ack: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == core_pm_pkg::PM_NAP_WAIT && !ack_s && !do_wake
        |=> state_reg != core_pm_pkg::PM_NAP)
        else $error("nap entered without acknowledge"); // R8
    chk_doze_direct: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == core_pm_pkg::PM_FULL && wr_cfg && pwdata[2:0] == 3'h1
        |=> state_reg == core_pm_pkg::PM_DOZE)
        else $error("doze not entered"); // R5
    chk_no_spont_entry: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == core_pm_pkg::PM_FULL && !wr_cfg |=> state_reg == core_pm_pkg::PM_FULL)
        else $error("spontaneous mode entry"); // R2
    chk_sleep_dec: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == core_pm_pkg::PM_SLEEP && ack_s && !mgmt_s && !int_s && !srst_s
        && !mcp_s |=> state_reg == core_pm_pkg::PM_SLEEP)
        else $error("sleep left without cause"); // R10
    chk_wake_two: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == core_pm_pkg::PM_DOZE && int_s
        |=> ##1 state_reg == core_pm_pkg::PM_FULL && !quiesce_request_o)
        else $error("doze wake slow"); // R7
    chk_nap_ack_loss: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == core_pm_pkg::PM_NAP && !ack_s |=> !quiesce_request_o)
        else $error("request held after acknowledge loss"); // R13
    chk_doze_snoop: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == core_pm_pkg::PM_DOZE |-> snoop_en_o && decrementer_en_o)
        else $error("doze lost snoop"); // R6

endmodule

// *** dv/quiesce_partner.sv ***
// Behavioural model of the peripheral logic side of the quiesce handshake.
module quiesce_partner
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // Quiesce handshake.
    input  wire logic       quiesce_request_i,
    output logic            quiesce_acknowledge_o,
    // Bench controls: acknowledge delay and forced negation.
    input  wire logic [3:0] delay_i,
    input  wire logic       drop_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_reg;  // Cycles still to wait before acknowledging.

    // ------------------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------------------
    // The acknowledge follows the request after a bench-chosen delay and then
    // stands while the request does; memory traffic never makes it negate, so
    // only the bench can withdraw it early to wake the core.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wait_reg              <= 4'h0;
            quiesce_acknowledge_o <= 1'b0;
        end
        else if (!quiesce_request_i || drop_i)
        begin
            wait_reg              <= delay_i;
            quiesce_acknowledge_o <= 1'b0;
        end
        else if (wait_reg != 4'h0)
        begin
            wait_reg <= wait_reg - 4'h1;
        end
        else
        begin
            quiesce_acknowledge_o <= 1'b1;
        end
    end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench of the core power-mode controller.
`include "core_pm_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic        clk_i, reset_i;               // Clock and reset.
    logic        psel, penable, pwrite;        // APB request.
    logic [11:0] paddr;                        // APB address.
    logic [31:0] pwdata, prdata;               // APB data.
    logic        pready, pslverr;              // APB answer.
    logic [4:0]  wake_src;                     // Management, int, dec, soft reset, check.
    logic        ack, req, drop;               // Quiesce handshake and forced drop.
    logic [3:0]  delay, demand, unit_on;       // Ack delay, dispatch demand, enables.
    logic        clk_en, snoop_en, dc_en, dec_en;  // Domain clock gates.
    logic [31:0] rd, seed;                     // Read data and random state.
    logic        err;                          // Slave error of the last transfer.
    int          miscompares, samples_checked; // Mismatch and comparison counts.

    core_power_mode_control #(.UNITS(4)) core_power_mode_control_i (
        .clk_i(clk_i), .reset_i(reset_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .system_mgmt_interrupt_i(wake_src[0]),
        .ext_int_i(wake_src[1]), .decrementer_exc_i(wake_src[2]),
        .soft_reset_i(wake_src[3]), .machine_check_i(wake_src[4]),
        .quiesce_acknowledge_i(ack), .quiesce_request_o(req),
        .dispatch_demand_i(demand), .unit_on_o(unit_on), .core_clk_en_o(clk_en),
        .snoop_en_o(snoop_en), .dcache_en_o(dc_en), .decrementer_en_o(dec_en));

    quiesce_partner quiesce_partner_i (
        .clk_i(clk_i), .reset_i(reset_i), .quiesce_request_i(req),
        .quiesce_acknowledge_o(ack), .delay_i(delay), .drop_i(drop));

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Xorshift generator; a fixed start keeps every run identical.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Wake-cause bit of a source; the ack-loss bit sits between dec and reset.
    function automatic logic [31:0] cause_bit(input int i);
        return (i < 3) ? (32'h1 << i) : (32'h1 << (i + 1));
    endfunction

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t %s: saw %h, expected %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        // A slave that never answers ends the run here rather than hanging.
        if (pready !== 1'b1)
        begin
            check(1'b0, 1'b1, "pready never came");
            test_done();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Polls the status word until it shows state, request and ack, bounded.
    task automatic wait_state(input logic [2:0] st, input logic q, input logic a);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `PM_OFS_STATUS, 32'h0);
            n++;
        end
        while ({rd[5:4], rd[2:0]} !== {a, q, st} && n < 30);
        check({27'h0, rd[5:4], rd[2:0]}, {27'h0, a, q, st}, "status");
    endtask

    // Raises one wake source for a few cycles.
    task automatic pulse(input int i);
        @(posedge clk_i);
        wake_src[i] <= 1'b1;
        repeat (4) @(posedge clk_i);
        wake_src[i] <= 1'b0;
    endtask

    // Reads the wake cause, compares it, then clears it by writing ones.
    task automatic cause_is(input logic [31:0] exp);
        apb(1'b0, `PM_OFS_WAKE_CAUSE, 32'h0);
        check(rd, exp, "wake cause");
        apb(1'b1, `PM_OFS_WAKE_CAUSE, 32'h3F);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // The tests need a few hundred cycles; this bound cuts a hang short.
    initial
    begin
        repeat (30000) @(posedge clk_i);
        check(1'b0, 1'b1, "watchdog expired");
        test_done();
    end

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {wake_src, drop, demand} = '0;
        delay = 4'h2;
        seed = 32'hA9D3;
        miscompares = 0;
        samples_checked = 0;
        reset_i = 1'b1;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        // Reset values, and no mode entered on its own.
        apb(1'b0, `PM_OFS_HW_CONFIG, 32'h0);
        check(rd, 32'h0, "config after reset");
        wait_state(core_pm_pkg::PM_FULL, 1'b0, 1'b0);
        check({28'h0, unit_on}, 32'hF, "units without gating");
        apb(1'b0, 12'h00C, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped read error");
        $display("test reset done");
        // Doze woken by each of its sources in turn.
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, `PM_OFS_HW_CONFIG, 32'h1);
            wait_state(core_pm_pkg::PM_DOZE, 1'b0, 1'b0);
            check({28'h0, clk_en, snoop_en, dc_en, dec_en}, 32'h7, "doze gates");
            pulse(i);
            wait_state(core_pm_pkg::PM_FULL, 1'b0, 1'b0);
            check({31'h0, clk_en}, 32'h1, "clock back");
            cause_is(cause_bit(i));
        end
        $display("test doze done");
        // Nap beats doze; dynamic management set; decrementer wakes; management survives.
        delay <= 4'(rnd()) & 4'h7;
        apb(1'b1, `PM_OFS_HW_CONFIG, 32'hB);
        wait_state(core_pm_pkg::PM_NAP, 1'b1, 1'b1);
        check({28'h0, clk_en, snoop_en, dc_en, dec_en}, 32'h1, "nap gates");
        pulse(2);
        wait_state(core_pm_pkg::PM_FULL, 1'b0, 1'b0);
        apb(1'b0, `PM_OFS_HW_CONFIG, 32'h0);
        check(rd, 32'h8, "config after nap");
        cause_is(32'h4);
        // Nap woken by the peripheral side withdrawing its acknowledge.
        delay <= 4'(rnd()) & 4'hF;
        apb(1'b1, `PM_OFS_HW_CONFIG, 32'h2);
        wait_state(core_pm_pkg::PM_NAP, 1'b1, 1'b1);
        drop <= 1'b1;
        wait_state(core_pm_pkg::PM_FULL, 1'b0, 1'b0);
        drop <= 1'b0;
        cause_is(32'h8);
        $display("test nap done");
        // Sleep beats nap and doze; decrementer ignored, external interrupt wakes.
        apb(1'b1, `PM_OFS_HW_CONFIG, 32'h7);
        wait_state(core_pm_pkg::PM_SLEEP, 1'b1, 1'b1);
        check({28'h0, clk_en, snoop_en, dc_en, dec_en}, 32'h0, "sleep gates");
        pulse(2);
        repeat (10) @(posedge clk_i);
        apb(1'b0, `PM_OFS_STATUS, 32'h0);
        check({29'h0, rd[2:0]}, {29'h0, core_pm_pkg::PM_SLEEP}, "still asleep");
        pulse(1);
        wait_state(core_pm_pkg::PM_FULL, 1'b0, 1'b0);
        cause_is(32'h2);
        $display("test sleep done");
        // Dispatch demand decides which units are powered.
        apb(1'b1, `PM_OFS_HW_CONFIG, 32'h8);
        repeat (10) @(posedge clk_i);
        check({28'h0, unit_on}, 32'h0, "idle units");
        for (int k = 0; k < 4; k++)
        begin
            demand <= 4'(rnd()) & 4'hF;
            repeat (8) @(posedge clk_i);
            check({28'h0, unit_on}, {28'h0, demand}, "demanded units");
        end
        $display("test demand done");
        test_done();
    end
endmodule
